/* include/cfg_latch_pkg.sv */
// Purpose: Shared constants for the channel configuration latch bank
// Assumes: Four channels, three latch banks per channel, 8-bit latches
// Notes: Byte address of a latch is four times its index
package cfg_latch_pkg;
  // Geometry
  localparam int CHANNELS = 4;
  localparam int BANKS = 3;
  localparam int LATCHES = 12;
  localparam int ADDR_W = 8;
  // Bank types within a channel, also the offset of the global address
  localparam int BANK_RX = 0;
  localparam int BANK_TX = 1;
  localparam int BANK_DYN = 2;
  // Latch indices (byte address = index * 4)
  localparam logic [3:0] IDX_GLOBAL_RX = 4'hC;
  localparam logic [3:0] IDX_GLOBAL_DYN = 4'hE;
  localparam logic [3:0] IDX_LAST_LOCAL = 4'hB;
  // Values after reset per bank type
  localparam logic [7:0] RESET_RX = 8'hBF;
  localparam logic [7:0] RESET_TX = 8'hAD;
  localparam logic [7:0] RESET_DYN = 8'hB3;
  // Bit positions common to every latch
  localparam int BIT_PARTICIPATE = 0;
  localparam int BIT_FORCE = 0;
  // Transmit static bank
  localparam int BIT_ENCODER_ON = 3;
  localparam int BIT_TX_SOURCE = 2;
  localparam int BIT_TX_MULT = 1;
  // Dynamic bank
  localparam int BIT_FRAMER = 7;
  localparam int BIT_RX_POWER = 6;
  localparam int BIT_RX_SELFTEST = 5;
  localparam int BIT_TX_SELFTEST = 4;
  localparam int BIT_SECONDARY = 3;
  localparam int BIT_PRIMARY = 2;
  localparam int BIT_RECENTRE = 1;
  // Transmit PLL multipliers
  localparam logic [4:0] PLL_FACTOR_LOW = 5'h0A;
  localparam logic [4:0] PLL_FACTOR_HIGH = 5'h14;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cfg_latch_pkg

/* include/chan_if.sv */
// Purpose: Carries one channel's dynamic bank to its recentre logic
// Assumes: Single clock domain
// Notes: Done pulse returns the self-clearing bit to one
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic [7:0] dyn_bank;
  logic recentre_done;
  modport store (output dyn_bank, input recentre_done);
  modport chan (input dyn_bank, output recentre_done);
endinterface : chan_if
`default_nettype wire

/* src/phase_recentre.sv */
// Purpose: Synchronises a phase buffer recentre request to the tx clock
// Assumes: tx_clk is sampled as an ordinary synchronous input
// Notes: One pulse per request, on the first sampled tx clock rise
`timescale 1ns/1ps
`default_nettype none
module phase_recentre
  import cfg_latch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  chan_if.chan link,
  input wire logic tx_clk,
  output logic recentre
);
  logic tx_prev;
  logic tx_rise;
  logic req;

  // Request is the recentre bit written low
  assign req = ~link.dyn_bank[BIT_RECENTRE];
  assign tx_rise = tx_clk & ~tx_prev;
  assign link.recentre_done = recentre;

  // Previous tx clock sample for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_prev <= 1'b0;
    end else begin
      tx_prev <= tx_clk;
    end
  end

  // Pulse blocked while the bit is being restored, avoids a double pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      recentre <= 1'b0;
    end else begin
      recentre <= req & tx_rise & ~recentre;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_armed;
    req && tx_rise && !recentre;
  endsequence

  a_recentre_edge: assert property (s_armed |=> recentre)
    else $error("recentre pulse missing after tx clock rise");
  a_recentre_cause: assert property (recentre |-> $past(req) && $past(tx_rise))
    else $error("recentre pulse without request and tx clock rise");
endmodule : phase_recentre
`default_nettype wire

/* src/channel_config_latch_bank.sv */
// Purpose: Per-channel configuration latches of a four-channel transceiver
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes: Global addresses are write-only and read as zero
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Encoder latch resets to 1 (encoder on); 0 sends raw 10-bit characters
// - Tx clock source latch resets to 1: reference clock, phase buffer bypassed
// - Tx clock source 0: input register clocked by the channel tx input clock
// - Multiplier latch resets to 0: PLL factor 10, output clock follows reference
// - Multiplier latch 1: PLL factor 20, output clock twice reference
// - Source and multiplier both 1: capture data on both reference edges
// - Framer latch resets to 1 enabling framing; 0 freezes frame offset
// - Receive power latch resets to 0; 1 powers receive PLL and analog
// - Receive self-test latch resets to 1 (off); 0 enables it
// - Transmit self-test latch resets to 1 (off); 0 enables it
// - Secondary driver latch resets to 0; 1 enables the driver
// - Primary driver latch resets to 0; 1 enables the driver
// - Disabled driver powered down; both disabled powers down channel logic
// - Device reset disables every serial driver on all channels
// - Recentre latch resets to 1; writing 0 recentres the phase buffer
// - Recentre request synchronised on rising edges of the tx input clock
// - Recentre latch returns to 1 by itself after the recentre
// - Participate bit resets to 1; at 0 global writes skip that address
// - Force bit in a global write updates all channels regardless
module channel_config_latch_bank
  import cfg_latch_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [CHANNELS-1:0] TX_INPUT_CLOCK,
  output logic [CHANNELS-1:0] ENCODER_ON,
  output logic [CHANNELS-1:0] TX_INPUT_CLOCK_SOURCE,
  output logic [CHANNELS-1:0] TX_PLL_MULTIPLIER_SELECT,
  output logic [5*CHANNELS-1:0] TX_PLL_FACTOR,
  output logic [CHANNELS-1:0] TX_DOUBLE_EDGE_CAPTURE,
  output logic [CHANNELS-1:0] FRAMER_ENABLE,
  output logic [CHANNELS-1:0] RX_CHANNEL_POWER_ON,
  output logic [CHANNELS-1:0] RX_SELFTEST_OFF,
  output logic [CHANNELS-1:0] TX_SELFTEST_OFF,
  output logic [CHANNELS-1:0] PRIMARY_DRIVER_ENABLE,
  output logic [CHANNELS-1:0] SECONDARY_DRIVER_ENABLE,
  output logic [CHANNELS-1:0] CHANNEL_LOGIC_POWER_ON,
  output logic [CHANNELS-1:0] PHASE_BUFFER_RECENTRE
);
  logic [7:0] latch [LATCHES];
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic wr_do;
  logic [3:0] widx;
  logic wr_hi_ok;
  logic wr_local;
  logic wr_global;
  logic [1:0] gtype;
  logic [3:0] ridx;
  logic rd_hi_ok;
  logic [CHANNELS-1:0] done;

  // Write channel ready while nothing is held and no response is pending
  assign AWREADY = ~aw_held & ~BVALID;
  assign WREADY = ~w_held & ~BVALID;
  assign ARREADY = ~RVALID;

  // Write decode on the held address
  assign widx = awaddr_q[5:2];
  assign wr_hi_ok = (awaddr_q[ADDR_W-1:6] == 2'h0) && (awaddr_q[1:0] == 2'h0);
  assign wr_do = aw_held & w_held & ~BVALID;
  assign wr_local = wr_hi_ok && (widx <= IDX_LAST_LOCAL);
  assign wr_global = wr_hi_ok && (widx >= IDX_GLOBAL_RX) && (widx <= IDX_GLOBAL_DYN);
  assign gtype = 2'(widx - IDX_GLOBAL_RX);

  // Read decode
  assign ridx = ARADDR[5:2];
  assign rd_hi_ok = (ARADDR[ADDR_W-1:6] == 2'h0) && (ARADDR[1:0] == 2'h0);

  // Address holding; address and data may arrive in either order
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      awaddr_q <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_held <= 1'b1;
      awaddr_q <= AWADDR;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  // Data holding; only byte lane 0 carries latch bits
  always_ff @(posedge CLK) begin
    if (RST) begin
      w_held <= 1'b0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_held <= 1'b1;
      wdata_q <= WDATA[7:0];
      wstrb_q <= WSTRB[0];
    end else if (wr_do) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge CLK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (wr_do) begin
      BVALID <= 1'b1;
      BRESP <= (wr_local || wr_global) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Read answer; global addresses are write-only and read as zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
      if (rd_hi_ok && ridx <= IDX_LAST_LOCAL) begin
        RDATA <= {24'h0, latch[ridx]};
      end else if (!(rd_hi_ok && ridx <= IDX_GLOBAL_DYN)) begin
        RRESP <= RESP_SLVERR;
      end
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Latch storage. Local write beats global write beats recentre restore,
  // so a fresh recentre request written with the restore is not lost.
  always_ff @(posedge CLK) begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      for (int t = 0; t < BANKS; t++) begin
        if (RST) begin
          unique case (t)
            BANK_RX: latch[ch*BANKS+t] <= RESET_RX;
            BANK_TX: latch[ch*BANKS+t] <= RESET_TX;
            default: latch[ch*BANKS+t] <= RESET_DYN;
          endcase
        end else if (wr_do && wstrb_q && wr_local && widx == 4'(ch*BANKS+t)) begin
          latch[ch*BANKS+t] <= wdata_q;
        end else if (wr_do && wstrb_q && wr_global && gtype == 2'(t)
                     && (latch[ch*BANKS+t][BIT_PARTICIPATE] || wdata_q[BIT_FORCE])) begin
          latch[ch*BANKS+t][7:1] <= wdata_q[7:1];
        end else if (t == BANK_DYN && done[ch]) begin
          latch[ch*BANKS+t][BIT_RECENTRE] <= 1'b1;
        end
      end
    end
  end

  // Per-channel decode of latch bits onto control outputs
  chan_if ch_if[CHANNELS] ();
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    localparam int TXK = g*BANKS + BANK_TX;
    localparam int DYK = g*BANKS + BANK_DYN;
    assign ENCODER_ON[g] = latch[TXK][BIT_ENCODER_ON];
    assign TX_INPUT_CLOCK_SOURCE[g] = latch[TXK][BIT_TX_SOURCE];
    assign TX_PLL_MULTIPLIER_SELECT[g] = latch[TXK][BIT_TX_MULT];
    // Factor for the serial bit clock PLL
    assign TX_PLL_FACTOR[g*5 +: 5] =
      latch[TXK][BIT_TX_MULT] ? PLL_FACTOR_HIGH : PLL_FACTOR_LOW;
    assign TX_DOUBLE_EDGE_CAPTURE[g] =
      latch[TXK][BIT_TX_SOURCE] & latch[TXK][BIT_TX_MULT];
    assign FRAMER_ENABLE[g] = latch[DYK][BIT_FRAMER];
    assign RX_CHANNEL_POWER_ON[g] = latch[DYK][BIT_RX_POWER];
    assign RX_SELFTEST_OFF[g] = latch[DYK][BIT_RX_SELFTEST];
    assign TX_SELFTEST_OFF[g] = latch[DYK][BIT_TX_SELFTEST];
    assign SECONDARY_DRIVER_ENABLE[g] = latch[DYK][BIT_SECONDARY];
    assign PRIMARY_DRIVER_ENABLE[g] = latch[DYK][BIT_PRIMARY];
    // Channel logic sleeps only when both drivers are off
    assign CHANNEL_LOGIC_POWER_ON[g] =
      latch[DYK][BIT_PRIMARY] | latch[DYK][BIT_SECONDARY];
    assign ch_if[g].dyn_bank = latch[DYK];
    assign done[g] = ch_if[g].recentre_done;
    // Recentre request crosses onto the tx input clock edges
    phase_recentre u_recentre (
      .clk(CLK),
      .rst(RST),
      .link(ch_if[g]),
      .tx_clk(TX_INPUT_CLOCK[g]),
      .recentre(PHASE_BUFFER_RECENTRE[g])
    );
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_local_write(int k);
    wr_do && wstrb_q && wr_local && widx == 4'(k);
  endsequence

  sequence s_global_tx_forced;
    wr_do && wstrb_q && wr_global && gtype == 2'(BANK_TX) && wdata_q[BIT_FORCE];
  endsequence

  a_drivers_reset: assert property (disable iff (1'b0)
    RST |=> PRIMARY_DRIVER_ENABLE == 4'h0 && SECONDARY_DRIVER_ENABLE == 4'h0)
    else $error("drivers not disabled after reset");
  a_tx_defaults: assert property ($past(RST) |->
    ENCODER_ON == 4'hF && TX_INPUT_CLOCK_SOURCE == 4'hF && TX_PLL_MULTIPLIER_SELECT == 4'h0)
    else $error("transmit latches wrong after reset");
  a_dyn_defaults: assert property ($past(RST) |->
    FRAMER_ENABLE == 4'hF && RX_CHANNEL_POWER_ON == 4'h0
    && RX_SELFTEST_OFF == 4'hF && TX_SELFTEST_OFF == 4'hF)
    else $error("dynamic latches wrong after reset");
  a_local_write: assert property (s_local_write(BANK_TX) |=>
    ENCODER_ON[0] == $past(wdata_q[BIT_ENCODER_ON])
    && TX_PLL_MULTIPLIER_SELECT[0] == $past(wdata_q[BIT_TX_MULT]))
    else $error("local write did not reach channel 0 transmit latch");
  a_local_isolated: assert property (s_local_write(BANK_TX) |=>
    $stable(latch[BANKS+BANK_TX]) && $stable(latch[BANK_DYN]))
    else $error("local write disturbed another latch");
  a_global_skip: assert property (wr_do && wr_global && gtype == 2'(BANK_RX)
    && !wdata_q[BIT_FORCE] && !latch[BANK_RX][BIT_PARTICIPATE]
    |=> $stable(latch[BANK_RX]))
    else $error("non-participating address took a global write");
  a_global_force: assert property (s_global_tx_forced |=>
    latch[3*BANKS+BANK_TX][7:1] == $past(wdata_q[7:1])
    && latch[BANK_TX][7:1] == $past(wdata_q[7:1]))
    else $error("forced global write missed a channel");
  a_pll_factor: assert property (TX_PLL_FACTOR[4:0] ==
    (TX_PLL_MULTIPLIER_SELECT[0] ? 5'h14 : 5'h0A))
    else $error("PLL factor does not match multiplier latch");
  a_double_edge: assert property (TX_DOUBLE_EDGE_CAPTURE[1] ==
    (TX_INPUT_CLOCK_SOURCE[1] && TX_PLL_MULTIPLIER_SELECT[1]))
    else $error("double edge capture wrong");
  a_logic_power: assert property (!PRIMARY_DRIVER_ENABLE[2] && !SECONDARY_DRIVER_ENABLE[2]
    |-> !CHANNEL_LOGIC_POWER_ON[2])
    else $error("channel logic powered with both drivers off");
  a_recentre_restore: assert property (PHASE_BUFFER_RECENTRE[0]
    && !(wr_do && wr_local && widx == 4'(BANK_DYN))
    |=> latch[BANK_DYN][BIT_RECENTRE])
    else $error("recentre bit did not clear itself");
  a_bresp_error: assert property (wr_do && !wr_local && !wr_global
    |=> BVALID && BRESP == 2'h2)
    else $error("unmapped write not answered with error");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
    |=> ##1 BVALID)
    else $error("write response not two cycles after both taken");
endmodule : channel_config_latch_bank
`default_nettype wire

/* sim/host_master.sv */
// Purpose: Register bus master standing in for the host logic
// Assumes: Tasks are entered right after a rising clock edge
// Notes: Answer ready lines stay high, so no answer is ever stalled
`timescale 1ns/1ps
`default_nettype none
module host_master
  import cfg_latch_pkg::*;
(
  input wire logic CLK,
  output logic [ADDR_W-1:0] AWADDR,
  output logic AWVALID,
  input wire logic AWREADY,
  output logic [31:0] WDATA,
  output logic [3:0] WSTRB,
  output logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  output logic BREADY,
  output logic [ADDR_W-1:0] ARADDR,
  output logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  output logic RREADY
);
  // Idle bus at time zero
  initial begin
    {AWADDR, AWVALID, WDATA, WSTRB, WVALID, ARADDR, ARVALID} = '0;
    {BREADY, RREADY} = 2'h3;
  end

  // Address and data offered together, each released once taken
  task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= s;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    r = BRESP;
  endtask : write

  // Single read, address released once taken, returns on the answer edge
  task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    d = RDATA;
    r = RRESP;
  endtask : read
endmodule : host_master
`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the configuration latch bank
// Assumes: Speed range select high on every channel
// Notes: Latch model kept here; outputs derived from it per channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfg_latch_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [CHANNELS-1:0] TX_INPUT_CLOCK = '0;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [CHANNELS-1:0] ENCODER_ON, TX_INPUT_CLOCK_SOURCE, TX_PLL_MULTIPLIER_SELECT;
  logic [CHANNELS-1:0] TX_DOUBLE_EDGE_CAPTURE, FRAMER_ENABLE, RX_CHANNEL_POWER_ON;
  logic [CHANNELS-1:0] RX_SELFTEST_OFF, TX_SELFTEST_OFF, PRIMARY_DRIVER_ENABLE;
  logic [CHANNELS-1:0] SECONDARY_DRIVER_ENABLE, CHANNEL_LOGIC_POWER_ON, PHASE_BUFFER_RECENTRE;
  logic [5*CHANNELS-1:0] TX_PLL_FACTOR;
  logic [7:0] lat [12];
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;

  host_master host (.CLK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  channel_config_latch_bank dut (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .TX_INPUT_CLOCK, .ENCODER_ON, .TX_INPUT_CLOCK_SOURCE,
    .TX_PLL_MULTIPLIER_SELECT, .TX_PLL_FACTOR, .TX_DOUBLE_EDGE_CAPTURE, .FRAMER_ENABLE,
    .RX_CHANNEL_POWER_ON, .RX_SELFTEST_OFF, .TX_SELFTEST_OFF, .PRIMARY_DRIVER_ENABLE,
    .SECONDARY_DRIVER_ENABLE, .CHANNEL_LOGIC_POWER_ON, .PHASE_BUFFER_RECENTRE);

  // 125 MHz clock
  always #4 CLK = ~CLK;

  // Hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%08h exp=%08h", $time, g, e);
    end
  endtask : cmp

  // Reset image per bank type: receive, transmit, dynamic
  task automatic reset_model();
    for (int i = 0; i < 12; i++) lat[i] = (i % 3 == 0) ? 8'hBF : (i % 3 == 1) ? 8'hAD : 8'hB3;
  endtask : reset_model

  // Expected output bundle of one channel from its transmit and dynamic latches
  function automatic logic [15:0] exp_ch(input int c);
    logic [7:0] t;
    logic [7:0] d;
    t = lat[c * 3 + 1];
    d = lat[c * 3 + 2];
    return {t[3], t[2], t[1], t[1] ? 5'h14 : 5'h0A, t[2] & t[1], d[7:4], d[2], d[3], d[3] | d[2]};
  endfunction : exp_ch

  function automatic logic [15:0] got_ch(input int c);
    return {ENCODER_ON[c], TX_INPUT_CLOCK_SOURCE[c], TX_PLL_MULTIPLIER_SELECT[c],
      TX_PLL_FACTOR[c * 5 +: 5], TX_DOUBLE_EDGE_CAPTURE[c], FRAMER_ENABLE[c],
      RX_CHANNEL_POWER_ON[c], RX_SELFTEST_OFF[c], TX_SELFTEST_OFF[c],
      PRIMARY_DRIVER_ENABLE[c], SECONDARY_DRIVER_ENABLE[c], CHANNEL_LOGIC_POWER_ON[c]};
  endfunction : got_ch

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    host.write(a, d, s, r);
    cmp(32'(r), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.read(a, d, r);
    cmp(d, e);
    cmp(32'(r), 32'(er));
  endtask : rd

  // Every latch read back, then every channel's outputs once settled
  task automatic chk_all();
    for (int i = 0; i < 12; i++) rd(8'(i * 4), 32'(lat[i]), RESP_OKAY);
    #1;
    for (int c = 0; c < 4; c++) cmp(32'(got_ch(c)), 32'(exp_ch(c)));
    @(posedge CLK);
  endtask : chk_all

  initial begin
    logic [31:0] d;
    logic [3:0] n;
    int i;
    int b;
    void'($urandom(32'hA93F));
    reset_model();
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk_all();
    $display("test reset values done");
    // Empty and full patterns first, then random; multiplier 1 is legal here
    for (int k = 0; k < 24; k++) begin
      i = $urandom_range(11);
      d = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : $urandom;
      if (i % 3 == 2) d[1] = 1'b1;
      wr(8'(i * 4), d, 4'h1, RESP_OKAY);
      lat[i] = d[7:0];
      chk_all();
    end
    $display("test local writes done");
    repeat (16) begin
      b = $urandom_range(2);
      d = $urandom;
      if (b == 2) d[1] = 1'b1;
      wr(8'((12 + b) * 4), d, 4'h1, RESP_OKAY);
      for (int c = 0; c < 4; c++)
        if (d[0] || lat[c * 3 + b][0]) lat[c * 3 + b][7:1] = d[7:1];
      rd(8'((12 + b) * 4), 32'h0, RESP_OKAY);
    end
    chk_all();
    $display("test global writes done");
    wr(8'h3C, 32'h0, 4'h1, RESP_SLVERR);
    wr(8'h05, 32'h0, 4'h1, RESP_SLVERR);
    wr(8'h40, 32'h0, 4'h1, RESP_SLVERR);
    wr(8'h00, 32'h0, 4'hE, RESP_OKAY);
    rd(8'h3C, 32'h0, RESP_SLVERR);
    chk_all();
    $display("test refused accesses done");
    for (int c = 0; c < 4; c++) begin
      lat[c * 3 + 2][1] = 1'b0;
      wr(8'((c * 3 + 2) * 4), 32'(lat[c * 3 + 2]), 4'h1, RESP_OKAY);
      rd(8'((c * 3 + 2) * 4), 32'(lat[c * 3 + 2]), RESP_OKAY);
      TX_INPUT_CLOCK[c] <= 1'b1;
      n = 4'h0;
      repeat (8) begin
        @(posedge CLK);
        #1;
        n = n + 4'(PHASE_BUFFER_RECENTRE[c]);
        cmp(32'(PHASE_BUFFER_RECENTRE & ~(4'h1 << c)), 32'h0);
      end
      cmp(32'(n), 32'h1);
      @(posedge CLK);
      TX_INPUT_CLOCK[c] <= 1'b0;
      lat[c * 3 + 2][1] = 1'b1;
      rd(8'((c * 3 + 2) * 4), 32'(lat[c * 3 + 2]), RESP_OKAY);
    end
    $display("test recentre done");
    wr(8'h38, 32'hFF, 4'h1, RESP_OKAY);
    for (int c = 0; c < 4; c++) lat[c * 3 + 2][7:1] = 7'h7F;
    chk_all();
    RST <= 1'b1;
    @(posedge CLK);
    @(posedge CLK);
    #1;
    cmp(32'(PRIMARY_DRIVER_ENABLE | SECONDARY_DRIVER_ENABLE), 32'h0);
    @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    reset_model();
    chk_all();
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
